// [verilog/bpadc_pkg.sv]
package bpadc_pkg;
  // Port widths
  localparam int P0_W = 7;
  localparam int P0_LO_W = 4;
  localparam int P2_W = 8;
  localparam int ADC_W = 8;
  localparam int ADC_SEL_W = 3;
  // Reset values
  localparam logic [6:0] P0_DATA_RST = 7'h00;
  localparam logic [7:0] P2_DATA_RST = 8'h00;
  localparam logic [7:0] P2_DIR_RST = 8'h00;
  localparam logic [7:0] PULLUP_RST = 8'h00;
  localparam logic [7:0] ADC_RES_RST = 8'h00;
  // Conversion timing in system clock cycles
  localparam int ADC_MAX_CYC = 35;
  localparam int ADC_CONV_CYC = 32;

  typedef enum logic [1:0] {
    BPADC_IDLE = 2'b00,
    BPADC_CONV = 2'b01,
    BPADC_DONE = 2'b11
  } bpadc_state_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pullup_en;
  } bpadc_p2_drive_t;

  typedef struct packed {
    logic [6:0] dout;
    logic [6:0] oe;
  } bpadc_p0_drive_t;
endpackage

// [verilog/bpadc_top.sv]
`timescale 1ns/1ns
`default_nettype none
module bpadc_top #(
  parameter bit REDUCED = 1'b0,
  parameter bit KEEP_LO = 1'b1,
  parameter int CONV_CYC = bpadc_pkg::ADC_CONV_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // First port control
  input wire logic p0_lo_out,
  input wire logic p0_hi_out,
  input wire logic [6:0] p0_wdata,
  output logic [6:0] p0_rdata,
  // First port pins
  input wire logic [6:0] first_port_lines_i,
  output logic [6:0] first_port_lines_o,
  output logic [6:0] first_port_lines_oe,
  // Second port control
  input wire logic [7:0] p2_dir_out,
  input wire logic [7:0] p2_wdata,
  input wire logic [7:0] second_port_pullup_select,
  output logic [7:0] p2_rdata,
  // Second port pins
  input wire logic [7:0] second_port_lines_i,
  output logic [7:0] second_port_lines_o,
  output logic [7:0] second_port_lines_oe,
  output logic [7:0] second_port_pullup_en,
  // Converter
  input wire logic adc_start,
  input wire logic [2:0] adc_chan,
  input wire logic [7:0] adc_sample,
  output logic [2:0] adc_mux_sel,
  output logic [7:0] adc_result,
  output logic adc_busy,
  output logic adc_done
);
  // Done lands CONV_CYC + 1 cycles after start; must stay inside the limit
  if (CONV_CYC < 1 || CONV_CYC > bpadc_pkg::ADC_MAX_CYC - 2) begin : g_bad_conv
    $error("CONV_CYC out of range");
  end

  // Which first-port lines exist, and which carry a keeper
  wire logic [6:0] p0_present = REDUCED ? 7'h07 : 7'h7F;
  wire logic [6:0] p0_keep = {4'hF, {3{KEEP_LO}}} & p0_present;
  // Direction by group: one control for lines 0-3, one for 4-6
  wire logic [6:0] p0_dir = {{3{p0_hi_out}}, {4{p0_lo_out}}} & p0_present;

  // Three-stage pin synchronisers
  logic [6:0] p0_s1_r, p0_s2_r, p0_s3_r, p0_val_r;
  logic [7:0] p2_s1_r, p2_s2_r, p2_s3_r, p2_val_r;
  always_ff @(posedge mclk) begin
    p0_s1_r <= first_port_lines_i;
    p0_s2_r <= p0_s1_r;
    p0_s3_r <= p0_s2_r;
    p2_s1_r <= second_port_lines_i;
    p2_s2_r <= p2_s1_r;
    p2_s3_r <= p2_s2_r;
  end

  // Accept a change only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_filt
      if (gi < 7) begin : g_p0
        always_ff @(posedge mclk) begin
          if (rst)
            p0_val_r[gi] <= 1'b0;
          else if (p0_s2_r[gi] == p0_s3_r[gi])
            p0_val_r[gi] <= p0_s3_r[gi];
        end
      end
      always_ff @(posedge mclk) begin
        if (rst)
          p2_val_r[gi] <= 1'b0;
        else if (p2_s2_r[gi] == p2_s3_r[gi])
          p2_val_r[gi] <= p2_s3_r[gi];
      end
    end
  endgenerate

  // Keeper drives back the last sensed level on undriven inputs
  wire logic [6:0] keep_drive = p0_keep & ~p0_dir;
  bpadc_pkg::bpadc_p0_drive_t p0_nxt, p0_r;
  assign p0_nxt.oe = p0_dir | keep_drive;
  assign p0_nxt.dout = (p0_dir & p0_wdata) | (keep_drive & p0_val_r);
  bpadc_pkg::bpadc_p2_drive_t p2_nxt, p2_r;
  assign p2_nxt.oe = p2_dir_out;
  assign p2_nxt.dout = p2_wdata & p2_dir_out;
  assign p2_nxt.pullup_en = second_port_pullup_select & ~p2_dir_out;

  always_ff @(posedge mclk) begin
    if (rst) begin
      p0_r <= '0;
      p2_r <= '0;
      p0_rdata <= bpadc_pkg::P0_DATA_RST;
      p2_rdata <= bpadc_pkg::P2_DATA_RST;
    end else begin
      p0_r <= p0_nxt;
      p2_r <= p2_nxt;
      p0_rdata <= p0_val_r & p0_present;
      p2_rdata <= p2_val_r;
    end
  end
  assign first_port_lines_o = p0_r.dout;
  assign first_port_lines_oe = p0_r.oe;
  assign second_port_lines_o = p2_r.dout;
  assign second_port_lines_oe = p2_r.oe;
  assign second_port_pullup_en = p2_r.pullup_en;

  // Converter sequencer; analog front end is outside this block
  bpadc_pkg::bpadc_state_t st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [2:0] sel_r;
  wire logic start_ok = adc_start && st_r == bpadc_pkg::BPADC_IDLE;
  wire logic conv_end = st_r == bpadc_pkg::BPADC_CONV && cnt_r == 6'(CONV_CYC - 1);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      bpadc_pkg::BPADC_IDLE: begin
        cnt_nxt = 6'h00;
        if (adc_start)
          st_nxt = bpadc_pkg::BPADC_CONV;
      end
      bpadc_pkg::BPADC_CONV: begin
        cnt_nxt = cnt_r + 6'h01;
        if (conv_end)
          st_nxt = bpadc_pkg::BPADC_DONE;
      end
      bpadc_pkg::BPADC_DONE:
        st_nxt = bpadc_pkg::BPADC_IDLE;
      default:
        st_nxt = bpadc_pkg::BPADC_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= bpadc_pkg::BPADC_IDLE;
      cnt_r <= 6'h00;
      sel_r <= 3'h0;
      adc_mux_sel <= 3'h0;
      adc_result <= bpadc_pkg::ADC_RES_RST;
      adc_busy <= 1'b0;
      adc_done <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      if (start_ok)
        sel_r <= adc_chan;
      adc_mux_sel <= start_ok ? adc_chan : sel_r;
      if (conv_end)
        adc_result <= adc_sample;
      adc_busy <= st_nxt == bpadc_pkg::BPADC_CONV;
      adc_done <= conv_end;
    end
  end

  property p_pullup_gate;
    @(posedge mclk) disable iff (rst)
      1'b1 |=> second_port_pullup_en == ($past(second_port_pullup_select) & ~$past(p2_dir_out));
  endproperty
  a_pullup_gate: assert property (p_pullup_gate) else $error("pull-up gating wrong");

  property p_out_no_pullup;
    @(posedge mclk) disable iff (rst)
      (second_port_lines_oe & second_port_pullup_en) == 8'h00;
  endproperty
  a_out_no_pullup: assert property (p_out_no_pullup) else $error("pull-up on output");

  property p_conv_time;
    @(posedge mclk) disable iff (rst)
      start_ok |-> ##[1:35] adc_done;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion too slow");

  property p_reset_inputs;
    @(posedge mclk) rst |=> (second_port_lines_oe == 8'h00 && first_port_lines_oe == 7'h00
      && second_port_pullup_en == 8'h00);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("reset state wrong");

  property p_reduced;
    @(posedge mclk) disable iff (rst)
      REDUCED |-> first_port_lines_oe[6:3] == 4'h0;
  endproperty
  a_reduced: assert property (p_reduced) else $error("absent lines driven");

  property p_group_dir;
    @(posedge mclk) disable iff (rst)
      !REDUCED && !$past(rst) && $past(p0_hi_out) |-> first_port_lines_oe[6:4] == 3'h7;
  endproperty
  a_group_dir: assert property (p_group_dir) else $error("group direction wrong");

  property p_keeper;
    @(posedge mclk) disable iff (rst)
      !REDUCED && !$past(rst) && !$past(p0_hi_out) |->
        first_port_lines_oe[6:4] == 3'h7 && first_port_lines_o[6:4] == $past(p0_val_r[6:4]);
  endproperty
  a_keeper: assert property (p_keeper) else $error("keeper not holding");

  property p_p2_dir;
    @(posedge mclk) disable iff (rst)
      1'b1 |=> second_port_lines_oe == $past(p2_dir_out);
  endproperty
  a_p2_dir: assert property (p_p2_dir) else $error("second port direction wrong");

  property p_result;
    @(posedge mclk) disable iff (rst)
      conv_end |=> adc_result == $past(adc_sample);
  endproperty
  a_result: assert property (p_result) else $error("result not stored");

  property p_mux;
    @(posedge mclk) disable iff (rst)
      start_ok |=> adc_mux_sel == $past(adc_chan);
  endproperty
  a_mux: assert property (p_mux) else $error("mux channel not taken");

  property p_mux_hold;
    @(posedge mclk) disable iff (rst)
      adc_busy |=> $stable(adc_mux_sel);
  endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("mux channel changed");

  c_conv: cover property (@(posedge mclk) disable iff (rst) start_ok ##[1:35] adc_done);
  c_pullup: cover property (@(posedge mclk) disable iff (rst) second_port_pullup_en != 8'h00);
  c_p0_out: cover property (@(posedge mclk) disable iff (rst) first_port_lines_oe == 7'h7F);
endmodule
`default_nettype wire

// [dv/bpadc_far.sv]
`timescale 1ns/1ns
`default_nettype none
module bpadc_far (
  // Clock
  input wire logic mclk,
  // Bench stimulus
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_v,
  // Design drive
  input wire logic [7:0] oe,
  input wire logic [7:0] o,
  input wire logic [7:0] pu,
  // Resolved pins
  output logic [7:0] pin
);
  logic [7:0] last_r = 8'h00;
  // Floating lines with no pull-up flip each cycle so a stale level never reads as valid
  assign pin = (ext_en & ext_v) | (~ext_en & oe & o) | (~ext_en & ~oe & (pu | ~last_r));
  always_ff @(posedge mclk) begin
    last_r <= pin;
  end
endmodule
`default_nettype wire

// [dv/test_bidir_ports_with_adc_mux.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module test_bidir_ports_with_adc_mux;
  logic mclk, rst, lo, hi, start, busy, done;
  logic [6:0] p0w, p0r, p0i, p0o, p0oe, rp0r, rp0oe, m;
  logic [7:0] dir, p2w, sel, p2r, p2i, p2o, p2oe, pue, samp, res, e0en, e0v, e2en, e2v, p0pin;
  logic [7:0] p2x;
  logic [2:0] chan, msel;
  int seed = 32'hc003;
  int n_mismatch = 0;
  int cmp_count = 0;
  int k, n;
  // Keeper off on lines 0-2 so the group direction shows on oe
  bpadc_top #(.KEEP_LO(1'b0)) DUT (.mclk(mclk), .rst(rst), .p0_lo_out(lo), .p0_hi_out(hi),
    .p0_wdata(p0w), .p0_rdata(p0r), .first_port_lines_i(p0i), .first_port_lines_o(p0o),
    .first_port_lines_oe(p0oe), .p2_dir_out(dir), .p2_wdata(p2w),
    .second_port_pullup_select(sel), .p2_rdata(p2r), .second_port_lines_i(p2i),
    .second_port_lines_o(p2o), .second_port_lines_oe(p2oe), .second_port_pullup_en(pue),
    .adc_start(start), .adc_chan(chan), .adc_sample(samp), .adc_mux_sel(msel),
    .adc_result(res), .adc_busy(busy), .adc_done(done));
  bpadc_top #(.REDUCED(1'b1)) RED (.mclk(mclk), .rst(rst), .p0_lo_out(lo), .p0_hi_out(hi),
    .p0_wdata(p0w), .p0_rdata(rp0r), .first_port_lines_i(p0i), .first_port_lines_o(),
    .first_port_lines_oe(rp0oe), .p2_dir_out(dir), .p2_wdata(p2w),
    .second_port_pullup_select(sel), .p2_rdata(), .second_port_lines_i(p2i),
    .second_port_lines_o(), .second_port_lines_oe(), .second_port_pullup_en(),
    .adc_start(start), .adc_chan(chan), .adc_sample(samp), .adc_mux_sel(),
    .adc_result(), .adc_busy(), .adc_done());
  bpadc_far FAR0 (.mclk(mclk), .ext_en(e0en), .ext_v(e0v), .oe({1'b0, p0oe}),
    .o({1'b0, p0o}), .pu(8'h00), .pin(p0pin));
  bpadc_far FAR2 (.mclk(mclk), .ext_en(e2en), .ext_v(e2v), .oe(p2oe), .o(p2o), .pu(pue),
    .pin(p2i));
  assign p0i = p0pin[6:0];
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    rst = 1'b1;
    {lo, hi, start, p0w, dir, p2w, sel, e0en, e0v, e2en, e2v, chan, samp} = '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    cyc(1);
    `CHK({p0oe[2:0], p2oe, pue, busy, done, res}, 29'h0)
    $display("test reset done");
    for (k = 0; k < 8; k++) begin
      @(posedge mclk);
      dir <= $random(seed);
      p2w <= $random(seed);
      sel <= $random(seed);
      cyc(2);
      `CHK(p2oe, dir)
      `CHK(p2o & dir, p2w & dir)
      `CHK(pue, sel & ~dir)
    end
    $display("test second port drive done");
    @(posedge mclk);
    dir <= 8'h00;
    sel <= 8'hFF;
    cyc(8);
    p2x = 8'hFF;
    `CHK(p2r, p2x)
    for (k = 0; k < 6; k++) begin
      @(posedge mclk);
      sel <= $random(seed);
      e2en <= $random(seed);
      e2v <= $random(seed);
      cyc(8);
      // Floating lines with no pull-up never settle, so the last level stays
      p2x = (e2en & e2v) | (~e2en & sel) | (~e2en & ~sel & p2x);
      `CHK(p2r, p2x)
    end
    $display("test second port input done");
    for (k = 0; k < 4; k++) begin
      @(posedge mclk);
      lo <= k[0];
      hi <= k[1];
      p0w <= $random(seed);
      cyc(3);
      m = {{3{hi}}, {4{lo}}};
      `CHK(p0oe[2:0], {3{lo}})
      `CHK(p0o & m, p0w & m)
      `CHK(p0oe[6:3], 4'hF)
      `CHK({rp0oe[6:3], rp0r[6:3]}, 8'h00)
    end
    $display("test first port groups done");
    @(posedge mclk);
    {lo, hi} <= 2'b00;
    e0en <= 8'h78;
    e0v <= $random(seed);
    cyc(8);
    `CHK(p0r[6:3], e0v[6:3])
    @(posedge mclk);
    e0en <= 8'h00;
    cyc(8);
    `CHK(p0o[6:3], e0v[6:3])
    `CHK(p0r[6:3], e0v[6:3])
    $display("test keeper done");
    for (k = 0; k < 8; k++) begin
      @(posedge mclk);
      chan <= k[2:0];
      samp <= $random(seed);
      start <= 1'b1;
      @(posedge mclk);
      // Second request while busy must be ignored
      chan <= ~k[2:0];
      @(posedge mclk);
      start <= 1'b0;
      cyc(1);
      `CHK(msel, k[2:0])
      `CHK(busy, 1'b1)
      for (n = 0; n < bpadc_pkg::ADC_MAX_CYC - 2 && done !== 1'b1; n++)
        cyc(1);
      `CHK(done, 1'b1)
      `CHK(busy, 1'b0)
      `CHK(res, samp)
      cyc(1);
      `CHK(done, 1'b0)
    end
    $display("test converter done");
    stop_test;
  end
endmodule
`default_nettype wire
